// File: hw/nco_regs.svh
// Offsets, field positions, reset values and timing counts of the serial load block.
`ifndef NCO_REGS_SVH
`define NCO_REGS_SVH
`define NCO_WORD_BITS        16
`define NCO_CNT_W            5
`define NCO_SCLK_DIV         4
`define NCO_CMD_HI           15
`define NCO_CMD_LO           14
`define NCO_CMD_CTRL         2'h0
`define NCO_CMD_FREQ0        2'h1
`define NCO_CMD_FREQ1        2'h2
`define NCO_CMD_PHASE        2'h3
`define NCO_PHASE_SEL_BIT    13
`define NCO_B28_BIT          13
`define NCO_HLB_BIT          12
`define NCO_SIGN_EN_BIT      5
`define NCO_DAC_PD_BIT       6
`define NCO_MODE_BIT         1
`define NCO_CTRL_RESET       16'h0000
`define NCO_ACC_W            28
`define NCO_DAC_W            10
`define NCO_ROM_AW           8
`define NCO_HOST_ADDR_DATA   2'h0
`define NCO_HOST_ADDR_STAT   2'h1
`endif

// File: hw/nco_pkg.sv
// Types shared by both ends of the serial load link.
`default_nettype none
package nco_pkg;
  typedef enum logic [1:0] {
    NCO_ST_IDLE,
    NCO_ST_LOW,
    NCO_ST_HIGH,
    NCO_ST_END
  } nco_host_st_t;
  typedef logic [15:0] nco_word_t;
endpackage
`default_nettype wire

// File: hw/nco_link_if.sv
// Serial write link between the host master and the oscillator device.
`default_nettype none
interface nco_link_if;
  logic sclk;
  logic sdata;
  logic frame_sync_n;
  logic frequency_register_select_pin;
  logic phase_select_pin;
  modport host (
    output sclk,
    output sdata,
    output frame_sync_n,
    output frequency_register_select_pin,
    output phase_select_pin
  );
  modport device (
    input sclk,
    input sdata,
    input frame_sync_n,
    input frequency_register_select_pin,
    input phase_select_pin
  );
endinterface
`default_nettype wire

// File: hw/nco_sync.sv
// Two flip-flop synchroniser for one level from another domain.
`default_nettype none
module nco_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic meta;
    logic stab;
  } nco_sync_st_t;
  nco_sync_st_t s_r;
  nco_sync_st_t s_nxt;
  always_comb begin
    s_nxt.meta = d;
    s_nxt.stab = s_r.meta;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign q = s_r.stab;
endmodule
`default_nettype wire

// File: hw/nco_device.sv
// Oscillator end: serial word capture, register file, accumulator and DAC data.
//
// The strobed register port and the placing of the registers were left to the implementer.
`include "nco_regs.svh"
`default_nettype none
module nco_device (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  nco_link_if.device                 link,
  input  wire logic                  dac_powerdown_pin,
  output logic [`NCO_DAC_W-1:0]      dac_current_outputs,
  output logic                       dac_enabled,
  output logic                       sign_output_enable,
  output logic                       dac_powerdown_bit,
  output logic                       word_taken,
  output nco_pkg::nco_word_t         control_word
);
  import nco_pkg::*;

  typedef struct packed {
    logic                       sclk_d;
    logic [`NCO_CNT_W-1:0]      cnt;
    nco_word_t                  shift;
    nco_word_t                  ctrl;
    logic [`NCO_ACC_W-1:0]      freq0;
    logic [`NCO_ACC_W-1:0]      freq1;
    logic [11:0]                phase0;
    logic [11:0]                phase1;
    logic [`NCO_ACC_W-1:0]      acc;
    logic [`NCO_DAC_W-1:0]      dac;
    logic                       dac_en;
    logic                       taken;
    logic                       armed;
  } nco_dev_st_t;

  nco_dev_st_t s_r;
  nco_dev_st_t s_nxt;
  logic        sclk_s;
  logic        sdata_s;
  logic        frame_sync_n_s;
  logic        fsel_s;
  logic        psel_s;
  logic        pd_s;
  logic [`NCO_DAC_W-1:0] sine_lookup_rom [0:(1<<`NCO_ROM_AW)-1];

  // Every pin from the host crosses into clk_sys through two flip-flops.
  // Each sclk level must outlast one clk_sys period to be seen, so the
  // fastest serial clock leaves little margin at this clk_sys rate.
  // Any rate within that limit, any idle.
  nco_sync u_sclk (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (link.sclk),
    .q       (sclk_s)
  );

  nco_sync u_sdat (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (link.sdata),
    .q       (sdata_s)
  );

  nco_sync u_fsyn (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (link.frame_sync_n),
    .q       (frame_sync_n_s)
  );

  nco_sync u_fsel (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (link.frequency_register_select_pin),
    .q       (fsel_s)
  );

  nco_sync u_psel (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (link.phase_select_pin),
    .q       (psel_s)
  );

  nco_sync u_pdwn (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (dac_powerdown_pin),
    .q       (pd_s)
  );

  // Quarter-wave-free table: a full cycle of sine, offset binary.
  // Real arithmetic only fills a constant table here; a flow that refuses
  // it needs the same codes written out as literals.
  always_comb begin
    for (int i = 0; i < (1 << `NCO_ROM_AW); i++) begin
      sine_lookup_rom[i] = `NCO_DAC_W'($rtoi(511.5 + 511.0 *
        $sin(6.283185307 * i / (1 << `NCO_ROM_AW))));
    end
  end

  always_comb begin
    logic                    fall;
    logic [`NCO_ACC_W-1:0]   step;
    logic [11:0]             poff;
    logic [`NCO_ACC_W-1:0]   ph;
    nco_word_t               w;
    s_nxt = s_r;
    fall  = s_r.sclk_d & ~sclk_s;
    step  = '0;
    poff  = '0;
    ph    = '0;
    w     = '0;
    s_nxt.sclk_d = sclk_s;
    s_nxt.taken  = 1'b0;
    // The frame input reads low until its synchroniser fills after reset,
    // so no frame is counted before the line has been seen high once.
    s_nxt.armed  = s_r.armed | frame_sync_n_s;
    if (frame_sync_n_s || !s_r.armed) begin
      s_nxt.cnt = '0;
    end else if (fall && s_r.cnt < `NCO_CNT_W'(`NCO_WORD_BITS)) begin
      s_nxt.shift = {s_r.shift[14:0], sdata_s};
      s_nxt.cnt   = s_r.cnt + `NCO_CNT_W'(1);
    end
    if (!frame_sync_n_s && s_r.cnt == `NCO_CNT_W'(`NCO_WORD_BITS)) begin
      w = s_r.shift;
      // Count moves past sixteen, so later falls in this frame are ignored.
      s_nxt.cnt   = s_r.cnt + `NCO_CNT_W'(1);
      s_nxt.taken = 1'b1;
      unique case (w[`NCO_CMD_HI:`NCO_CMD_LO])
        `NCO_CMD_CTRL: s_nxt.ctrl = w;
        // A half-word write keeps the other half, so a full load takes two with B28 clear.
        `NCO_CMD_FREQ0: begin
          if (s_r.ctrl[`NCO_HLB_BIT] && !s_r.ctrl[`NCO_B28_BIT]) begin
            s_nxt.freq0[27:14] = w[13:0];
          end else begin
            s_nxt.freq0[13:0] = w[13:0];
          end
        end
        `NCO_CMD_FREQ1: begin
          if (s_r.ctrl[`NCO_HLB_BIT] && !s_r.ctrl[`NCO_B28_BIT]) begin
            s_nxt.freq1[27:14] = w[13:0];
          end else begin
            s_nxt.freq1[13:0] = w[13:0];
          end
        end
        `NCO_CMD_PHASE: begin
          if (w[`NCO_PHASE_SEL_BIT]) begin
            s_nxt.phase1 = w[11:0];
          end else begin
            s_nxt.phase0 = w[11:0];
          end
        end
      endcase
    end
    step = fsel_s ? s_r.freq1 : s_r.freq0;
    poff = psel_s ? s_r.phase1 : s_r.phase0;
    s_nxt.acc = s_r.acc + step;
    ph = s_r.acc + {poff, 16'h0000};
    // Waveform bit set gives sinusoid.
    // The reserved mix of sign enable and ramp is shown as the sinusoid.
    // Sign enable forces the sinusoid.
    if (s_r.ctrl[`NCO_MODE_BIT] || s_r.ctrl[`NCO_SIGN_EN_BIT]) begin
      s_nxt.dac = sine_lookup_rom[ph[`NCO_ACC_W-1 -: `NCO_ROM_AW]];
    end else begin
      s_nxt.dac = ph[`NCO_ACC_W-1] ? ~ph[`NCO_ACC_W-2 -: `NCO_DAC_W]
                                    : ph[`NCO_ACC_W-2 -: `NCO_DAC_W];
    end
    // A powered-down DAC shows code zero, so no stale sample leaks out.
    s_nxt.dac_en = ~pd_s & ~s_r.ctrl[`NCO_DAC_PD_BIT];
    if (!s_nxt.dac_en) begin
      s_nxt.dac = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // Clearing all state makes the first output the ramp at phase zero.
      s_r      <= '0;
      s_r.ctrl <= `NCO_CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dac_current_outputs = s_r.dac;
  assign dac_enabled         = s_r.dac_en;
  assign sign_output_enable  = s_r.ctrl[`NCO_SIGN_EN_BIT];
  assign dac_powerdown_bit   = s_r.ctrl[`NCO_DAC_PD_BIT];
  assign word_taken          = s_r.taken;
  assign control_word        = s_r.ctrl;
endmodule
`default_nettype wire

// File: hw/nco_host.sv
// Host end: serial master that sends 16-bit words ordered over a plain port.
`include "nco_regs.svh"
`default_nettype none
module nco_host (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  nco_link_if.host         link,
  input  wire logic [1:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata
);
  import nco_pkg::*;

  typedef struct packed {
    nco_host_st_t            st;
    nco_word_t               sh;
    logic [`NCO_CNT_W-1:0]   bits;
    logic [1:0]              div;
    logic                    sclk;
    logic                    fs_n;
    logic                    sdata;
    logic                    fsel;
    logic                    psel;
    logic [15:0]             rdata;
  } nco_host_state_t;

  nco_host_state_t s_r;
  nco_host_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = '0;
    if (rd) begin
      unique case (addr)
        `NCO_HOST_ADDR_STAT: s_nxt.rdata = {14'h0000, s_r.st != NCO_ST_IDLE,
                                            s_r.fs_n};
        default:             s_nxt.rdata = '0;
      endcase
    end
    if (wr && addr == `NCO_HOST_ADDR_STAT) begin
      s_nxt.fsel = wdata[0];
      s_nxt.psel = wdata[1];
    end
    s_nxt.div = s_r.div + 2'h1;
    unique case (s_r.st)
      NCO_ST_IDLE: begin
        s_nxt.sclk = 1'b1;
        s_nxt.fs_n = 1'b1;
        if (wr && addr == `NCO_HOST_ADDR_DATA) begin
          s_nxt.sh    = wdata;
          s_nxt.fs_n  = 1'b0;
          s_nxt.sdata = wdata[15];
          s_nxt.bits  = '0;
          s_nxt.div   = '0;
          s_nxt.st    = NCO_ST_HIGH;
        end
      end
      NCO_ST_HIGH: begin
        if (s_r.div == 2'(`NCO_SCLK_DIV - 1)) begin
          s_nxt.sclk = 1'b0;
          s_nxt.bits = s_r.bits + `NCO_CNT_W'(1);
          s_nxt.st   = NCO_ST_LOW;
        end
      end
      NCO_ST_LOW: begin
        if (s_r.div == 2'(`NCO_SCLK_DIV - 1)) begin
          s_nxt.sclk = 1'b1;
          if (s_r.bits == `NCO_CNT_W'(`NCO_WORD_BITS)) begin
            s_nxt.st = NCO_ST_END;
          end else begin
            s_nxt.sh    = {s_r.sh[14:0], 1'b0};
            s_nxt.sdata = s_r.sh[14];
            s_nxt.st    = NCO_ST_HIGH;
          end
        end
      end
      NCO_ST_END: begin
        if (s_r.div == 2'(`NCO_SCLK_DIV - 1)) begin
          s_nxt.fs_n = 1'b1;
          s_nxt.st   = NCO_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r      <= '0;
      s_r.st   <= NCO_ST_IDLE;
      s_r.sclk <= 1'b1;
      s_r.fs_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.sclk  = s_r.sclk;
  assign link.sdata = s_r.sdata;
  assign link.frame_sync_n = s_r.fs_n;
  assign link.frequency_register_select_pin = s_r.fsel;
  assign link.phase_select_pin = s_r.psel;
  assign rdata = s_r.rdata;
endmodule
`default_nettype wire

// File: tb/nco_link_sva.sv
// Protocol checks on the serial load link between host and device ends.
`default_nettype none
module nco_link_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic frame_sync_n,
  input wire logic frequency_register_select_pin,
  input wire logic phase_select_pin
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [4:0] fall_cnt_r;
  logic [7:0] low_cnt_r;
  // Counters restart with every frame so a word split over frames is caught.
  always_ff @(posedge clk_sys) begin
    if (rst || frame_sync_n) begin
      fall_cnt_r <= 5'h00;
      low_cnt_r  <= 8'h00;
    end else begin
      low_cnt_r <= low_cnt_r + 8'h01;
      if ($fell(sclk)) begin
        fall_cnt_r <= fall_cnt_r + 5'h01;
      end
    end
  end
  a_idle_clk_high: assert property (
    frame_sync_n |-> sclk) else $error("sclk low outside a frame");
  a_data_on_rise: assert property (
    !frame_sync_n && !$past(frame_sync_n) && $changed(sdata) |-> $rose(sclk))
    else $error("sdata changed away from a rising sclk");
  a_sclk_half_period: assert property (
    $changed(sclk) |=> $stable(sclk)[*3]) else $error("sclk half too short");
  a_frame_sixteen_falls: assert property (
    $rose(frame_sync_n) |-> fall_cnt_r == 5'h10)
    else $error("frame did not carry sixteen bits");
  a_fall_count_max: assert property (
    fall_cnt_r <= 5'h10) else $error("more than sixteen falls in a frame");
  a_frame_length_max: assert property (
    low_cnt_r < 8'hC8) else $error("frame held low too long");
  a_first_bit_setup: assert property (
    $fell(frame_sync_n) |-> sclk[*4]) else $error("sclk fell too soon");
  a_frame_end_hold: assert property (
    $rose(frame_sync_n) |-> $past(sclk, 4))
    else $error("frame ended too close to last fall");
  c_frame_done: cover property ($rose(frame_sync_n));
  c_freq_pin: cover property ($rose(frequency_register_select_pin));
  c_phase_pin: cover property ($rose(phase_select_pin));
endmodule
`default_nettype wire

// File: tb/dds_serial_load_and_output_select_tb.sv
// Bench joining host and device ends, plus a bench-driven second device.
`default_nettype none
module dds_serial_load_and_output_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nco_pkg::*;
  logic        clk_sys, rst, wr, rd, pd_pin, en, sgn, pdb, taken, sgn2;
  logic        taken2;
  logic [1:0]  addr;
  logic [15:0] wdata, rdata, got;
  logic [9:0]  dac;
  nco_word_t   cw, cw2;
  int          n_fail, tests_run, n_take, n_take2;
  nco_link_if link ();
  nco_link_if link2 ();
  nco_host nco_host_inst (.clk_sys(clk_sys), .rst(rst), .link(link),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  nco_device nco_device_inst (.clk_sys(clk_sys), .rst(rst), .link(link),
    .dac_powerdown_pin(pd_pin), .dac_current_outputs(dac),
    .dac_enabled(en), .sign_output_enable(sgn), .dac_powerdown_bit(pdb),
    .word_taken(taken), .control_word(cw));
  nco_device nco_device_inst2 (.clk_sys(clk_sys), .rst(rst), .link(link2),
    .dac_powerdown_pin(1'b0), .dac_current_outputs(), .dac_enabled(),
    .sign_output_enable(sgn2), .dac_powerdown_bit(), .word_taken(taken2),
    .control_word(cw2));
  nco_link_sva nco_link_sva_inst (.clk_sys(clk_sys), .rst(rst),
    .sclk(link.sclk), .sdata(link.sdata), .frame_sync_n(link.frame_sync_n),
    .frequency_register_select_pin(link.frequency_register_select_pin),
    .phase_select_pin(link.phase_select_pin));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (taken === 1'b1) n_take++;
    if (taken2 === 1'b1) n_take2++;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e,
                     input string m);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [1:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  // The poll is bounded so a stuck busy flag shows up as a mismatch.
  task automatic wait_idle;
    for (int i = 0; i < 150; i++) begin
      bus_rd(2'h1);
      if (got[1] === 1'b0) break;
    end
    chk(got, 16'h0001, "host still busy");
    repeat (8) @(posedge clk_sys);
  endtask
  // The released data line is inverted so a stale level is never read.
  task automatic send2(input nco_word_t w, input int n);
    link2.frame_sync_n <= 1'b0;
    link2.sdata        <= w[15];
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      link2.sclk <= 1'b0;
      repeat (8) @(posedge clk_sys);
      w = w << 1;
      link2.sclk  <= 1'b1;
      link2.sdata <= w[15];
      repeat (8) @(posedge clk_sys);
    end
    link2.frame_sync_n <= 1'b1;
    link2.sdata        <= ~w[15];
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic summarize;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #100us;
    n_fail++;
    $display("FAIL %0t watchdog expired", $time);
    summarize;
  end
  initial begin
    {rst, wr, rd, addr, wdata, pd_pin} = {1'b1, 21'h0};
    {n_fail, tests_run, n_take, n_take2} = '0;
    link2.sclk = 1'b1;
    link2.sdata = 1'b0;
    link2.frame_sync_n = 1'b1;
    link2.frequency_register_select_pin = 1'b0;
    link2.phase_select_pin = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    bus_rd(2'h1);
    chk(got, 16'h0001, "status after reset");
    chk({15'h0, en}, 16'h0001, "dac on after reset");
    $display("test reset done");
    bus_wr(2'h0, 16'h0002);
    bus_rd(2'h1);
    chk(got, 16'h0002, "frame open");
    wait_idle;
    chk(cw, 16'h0002, "control word");
    chk({14'h0, sgn, pdb}, 16'h0000, "sine flags");
    $display("test word done");
    bus_wr(2'h0, 16'h0060);
    bus_wr(2'h0, 16'h0002);
    wait_idle;
    chk(cw, 16'h0060, "write during busy");
    chk({13'h0, sgn, pdb, en}, 16'h0006, "powerdown bit");
    chk({6'h0, dac}, 16'h0000, "dac silent");
    bus_wr(2'h0, 16'h0002);
    wait_idle;
    pd_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk({15'h0, en}, 16'h0000, "powerdown pin");
    chk(n_take[15:0], 16'h0003, "accepted words");
    pd_pin <= 1'b0;
    $display("test powerdown done");
    bus_wr(2'h1, 16'h0003);
    repeat (2) @(posedge clk_sys);
    chk({14'h0, link.phase_select_pin, link.frequency_register_select_pin},
        16'h0003, "select pins");
    bus_wr(2'h1, 16'h0002);
    repeat (2) @(posedge clk_sys);
    chk({14'h0, link.phase_select_pin, link.frequency_register_select_pin},
        16'h0002, "select pins");
    $display("test pins done");
    // Frequencies are still zero, so the phase offset alone sets the code.
    bus_wr(2'h0, 16'hE400);
    wait_idle;
    chk({6'h0, dac}, 16'h03FE, "sine peak on phase 1");
    bus_wr(2'h1, 16'h0000);
    repeat (8) @(posedge clk_sys);
    chk({6'h0, dac}, 16'h01FF, "sine midscale on phase 0");
    bus_wr(2'h0, 16'h0000);
    wait_idle;
    chk({6'h0, dac}, 16'h0000, "ramp start on phase 0");
    bus_wr(2'h1, 16'h0002);
    repeat (8) @(posedge clk_sys);
    chk({6'h0, dac}, 16'h0200, "ramp on phase 1");
    $display("test waveform done");
    bus_wr(2'h0, 16'hBFFF);
    wait_idle;
    chk({6'h0, dac}, 16'h0200, "frequency 0 still zero");
    bus_wr(2'h1, 16'h0003);
    repeat (8) @(posedge clk_sys);
    got = {6'h0, dac};
    repeat (40) @(posedge clk_sys);
    chk({15'h0, dac != got[9:0]}, 16'h0001, "frequency 1 moves");
    bus_wr(2'h1, 16'h0002);
    repeat (8) @(posedge clk_sys);
    got = {6'h0, dac};
    repeat (40) @(posedge clk_sys);
    chk({6'h0, dac}, got, "frequency 0 holds");
    $display("test frequency done");
    send2(16'h0062, 8);
    chk(cw2, 16'h0000, "short frame");
    send2(16'h0022, 16);
    chk(cw2, 16'h0022, "bench word");
    chk({14'h0, sgn2, n_take2[0]}, 16'h0003, "sign enable");
    $display("test bench frames done");
    summarize;
  end
endmodule
`default_nettype wire
